//--- hw/meas_ctl_cfg.svh
// Constants for the measurement control block
`ifndef MEAS_CTL_CFG_SVH
`define MEAS_CTL_CFG_SVH
`define CLK_HZ              10000000
`define RES_MIN             4'h3
`define RES_MAX             4'h8
`define RES_RESET           4'h6
`define RATIO_MAX_DIGITS    4'h8
`define PHASE_HI_DIGITS     4'h3
`define PHASE_LO_DIGITS     4'h4
`define TOTAL_MAX           32'h05F5E0FF
`define AVG_COUNT           7'h64
`define DELAY_UNIT_US       200
`define DELAY_MIN           13'h0001
`define DELAY_MAX           13'h0FA0
`define DELAY_RESET         13'h0032
`define MS_CYCLES           (`CLK_HZ / 1000)
`define GATE_MS_RES8        14'h2710
`define GATE_MS_RES7        14'h03E8
`define GATE_MS_RES6        14'h0064
`define GATE_MS_RES5        14'h000A
`define GATE_MS_RES4        14'h0001
`define PHASE_GATE_MS       50
`define PHASE_SLOW_GATE_MS  500
`define SPECIAL_HOLD_MS     3000
`define BLINK_HALF_MS       1500
`define ERR_NONE            6'h00
`define ERR_PHASE_FREQ      6'h01
`define ERR_RANGE           6'h02
`define ERR_CNT_OVF         6'h03
`define ERR_ENTRY           6'h04
`define ERR_PROG            6'h05
`define ERR_PHASE_HI        6'h06
`define ERR_CHECK           6'h32
`endif

//--- hw/meas_ctl_pkg.sv
// Types shared by the measurement control block
package meas_ctl_pkg;
	typedef enum logic [3:0] {
		FN_FREQ_A  = 4'h0,
		FN_PERIOD  = 4'h1,
		FN_TI      = 4'h2,
		FN_GATED_TOTAL = 4'h3,
		FN_PHASE   = 4'h4,
		FN_RATIO   = 4'h5,
		FN_CHECK   = 4'h6,
		FN_TOTAL_A = 4'h7,
		FN_TIME    = 4'h8
	} func_e;
	typedef enum logic [1:0] {
		ST_MEASURE = 2'b00,
		ST_DELAY_EDIT = 2'b01,
		ST_LED_CHECK = 2'b10
	} mode_e;
endpackage

//--- hw/ms_tick.sv
// One millisecond enable pulse divider
`timescale 1ns/1ns
`include "meas_ctl_cfg.svh"
module ms_tick #(
	parameter int CYCLES = `MS_CYCLES
) (
	input  wire logic mclk,
	input  wire logic resetn,
	output logic      tick
);
	logic [15:0] cnt_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 16'h0000;
			tick  <= 1'b0;
		end else if (cnt_q == 16'(CYCLES - 1)) begin
			cnt_q <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick  <= 1'b0;
		end
	end
endmodule // ms_tick

//--- hw/ms_timer.sv
// Millisecond down-counter that pulses done when it expires
`timescale 1ns/1ns
module ms_timer #(
	parameter int W = 13
) (
	input  wire logic         mclk,
	input  wire logic         resetn,
	input  wire logic         tick,
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	output logic              done,
	output logic              busy
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else if (start) begin
			cnt_q <= load;
			busy  <= 1'b1;
			done  <= 1'b0;
		end else if (busy && tick) begin
			if (cnt_q <= W'(1)) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else begin
				cnt_q <= cnt_q - W'(1);
				done  <= 1'b0;
			end
		end else begin
			done <= 1'b0;
		end
	end
endmodule // ms_timer

//--- hw/meas_ctl.sv
// Measurement control: resolution, gate time, offset, delay, averaging, errors
`timescale 1ns/1ns
`include "meas_ctl_cfg.svh"
module meas_ctl
	import meas_ctl_pkg::*;
#(
	parameter int DW        = 32,
	parameter int HOLD_MS   = `SPECIAL_HOLD_MS,
	parameter int BLINK_MS  = `BLINK_HALF_MS,
	parameter int TICK_CYC  = `MS_CYCLES
) (
	input  wire logic          mclk,
	input  wire logic          resetn,
	input  wire logic [3:0]    func_sel,
	input  wire logic          key_res_up,
	input  wire logic          key_res_down,
	input  wire logic          key_null,
	input  wire logic          key_delay_raw,
	input  wire logic          key_up,
	input  wire logic          key_down,
	input  wire logic          key_reset,
	input  wire logic          key_recall,
	input  wire logic          key_hundred_reading_average,
	input  wire logic          gate_done,
	input  wire logic [DW-1:0] meas_value,
	input  wire logic          meas_ovf,
	input  wire logic          cnt_ovf,
	input  wire logic          phase_freq_mismatch,
	input  wire logic          phase_in_above_5mhz,
	input  wire logic          phase_in_above_100khz,
	input  wire logic          phase_in_above_200hz,
	input  wire logic          entry_err,
	input  wire logic          prog_err,
	input  wire logic          check_fail,
	output logic [3:0]         resolution,
	output logic [3:0]         digits_shown,
	output logic               half_zero_pad,
	output logic               exp_notation,
	output logic               overflow_led,
	output logic [13:0]        gate_ms,
	output logic               gate_avg,
	output logic               res_ctrl_led,
	output logic               null_led,
	output logic [DW-1:0]      display_value,
	output logic [DW-1:0]      null_store,
	output logic               delay_led,
	output logic               delay_en,
	output logic [12:0]        delay_val,
	output logic               chan_b_freq,
	output logic               avg_led,
	output logic               gate_led,
	output logic [DW-1:0]      avg_value,
	output logic               avg_valid,
	output logic               blink_on,
	output logic [5:0]         err_code
);
	logic [3:0]    res_q;
	logic [3:0]    func_q;
	mode_e         mode_q;
	logic          null_q;
	logic          dly_en_q;
	logic          chb_q;
	logic          avg_q;
	logic [6:0]    avg_cnt_q;
	logic [DW+6:0] avg_sum_q;
	logic [DW-1:0] result;
	logic          sync1_q;
	logic          key_delay;
	logic          dly_prev_q;
	logic          tick;
	logic [12:0]   hold_q;
	logic          hold_fired_q;
	logic          blink_start;
	logic          blink_done;
	logic          blink_busy;
	logic          func_chg;
	logic          res_ok;
	logic          null_ok;
	logic          dly_ok;
	logic          dly_press;
	logic          dly_release;

	// Delay key bounces off the panel; synchronise before use
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sync1_q    <= 1'b0;
			key_delay  <= 1'b0;
			dly_prev_q <= 1'b0;
		end else begin
			sync1_q    <= key_delay_raw;
			key_delay  <= sync1_q;
			dly_prev_q <= key_delay;
		end
	end
	assign dly_press   = key_delay & ~dly_prev_q;
	assign dly_release = ~key_delay & dly_prev_q;

	ms_tick #(.CYCLES(TICK_CYC)) u_tick (
		.mclk   (mclk),
		.resetn (resetn),
		.tick   (tick)
	);

	assign func_chg = (func_sel != func_q);
	assign res_ok   = (func_q != FN_GATED_TOTAL) && (func_q != FN_TOTAL_A)
		&& (func_q != FN_PHASE) && (mode_q == ST_MEASURE);
	assign null_ok  = (func_q != FN_PHASE) && (func_q != FN_CHECK);
	assign dly_ok   = (func_q == FN_TI) || (func_q == FN_GATED_TOTAL);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			func_q <= 4'h0;
		else
			func_q <= func_sel;
	end

	// Resolution setting
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			res_q <= `RES_RESET;
		end else if (res_ok) begin
			if (key_res_up && res_q < `RES_MAX)
				res_q <= res_q + 4'h1;
			else if (key_res_down && res_q > `RES_MIN)
				res_q <= res_q - 4'h1;
		end
	end

	// Mode: measuring, delay entry, LED check
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= ST_MEASURE;
		end else if (func_chg) begin
			mode_q <= ST_MEASURE;
		end else begin
			unique case (mode_q)
				ST_MEASURE: begin
					if (func_q == FN_CHECK && key_recall)
						mode_q <= ST_LED_CHECK;
					else if (dly_ok && (key_up || key_down))
						mode_q <= ST_DELAY_EDIT;
				end
				ST_DELAY_EDIT: begin
					if (key_reset || dly_press)
						mode_q <= ST_MEASURE;
				end
				ST_LED_CHECK: begin
					if (key_reset)
						mode_q <= ST_MEASURE;
				end
				default: mode_q <= ST_MEASURE;
			endcase
		end
	end

	// Delay store, kept through standby since only power-on resets it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			delay_val <= `DELAY_RESET;
		end else if (dly_ok && mode_q != ST_LED_CHECK) begin
			if (key_up && delay_val < `DELAY_MAX)
				delay_val <= delay_val + 13'h0001;
			else if (key_down && delay_val > `DELAY_MIN)
				delay_val <= delay_val - 13'h0001;
		end
	end

	// Delay enable toggle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			dly_en_q <= 1'b0;
		else if (!dly_ok)
			dly_en_q <= 1'b0;
		else if (mode_q == ST_DELAY_EDIT && dly_press)
			dly_en_q <= 1'b1;
		else if (mode_q == ST_MEASURE && dly_press)
			dly_en_q <= ~dly_en_q;
	end

	// Channel B frequency: delay key held three seconds in frequency A
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hold_q       <= 13'h0000;
			hold_fired_q <= 1'b0;
			chb_q        <= 1'b0;
		end else if (func_q != FN_FREQ_A || func_chg) begin
			hold_q       <= 13'h0000;
			hold_fired_q <= 1'b0;
			chb_q        <= 1'b0;
		end else if (!key_delay) begin
			hold_q       <= 13'h0000;
			if (dly_release)
				hold_fired_q <= 1'b0;
			if (key_reset)
				chb_q <= 1'b0;
		end else if (dly_press && chb_q) begin
			chb_q        <= 1'b0;
			hold_fired_q <= 1'b1;
		end else if (!hold_fired_q && tick) begin
			if (hold_q == 13'(HOLD_MS - 1)) begin
				chb_q        <= 1'b1;
				hold_fired_q <= 1'b1;
			end else begin
				hold_q <= hold_q + 13'h0001;
			end
		end
	end

	// Blink half period timer, held loaded until the LED check starts
	ms_timer #(.W(13)) u_blink (
		.mclk   (mclk),
		.resetn (resetn),
		.tick   (tick),
		.start  (blink_start),
		.load   (13'(BLINK_MS)),
		.done   (blink_done),
		.busy   (blink_busy)
	);
	assign blink_start = (mode_q != ST_LED_CHECK) || !blink_busy;

	// LED check blink on a three-second cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			blink_on <= 1'b0;
		else if (mode_q != ST_LED_CHECK)
			blink_on <= 1'b0;
		else if (blink_done)
			blink_on <= ~blink_on;
	end

	// Offset subtract
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			null_q     <= 1'b0;
			null_store <= '0;
		end else if (!null_ok) begin
			null_q <= 1'b0;
		end else if (key_null && !null_q) begin
			null_q     <= 1'b1;
			null_store <= display_value;
		end else if (key_null) begin
			null_q <= 1'b0;
		end
	end

	// Hundred-reading averaging
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			avg_q     <= 1'b0;
			avg_cnt_q <= 7'h00;
			avg_sum_q <= '0;
			avg_value <= '0;
			avg_valid <= 1'b0;
		end else begin
			avg_valid <= 1'b0;
			if (key_hundred_reading_average)
				avg_q <= ~avg_q;
			if (!avg_q || key_reset || func_chg) begin
				avg_cnt_q <= 7'h00;
				avg_sum_q <= '0;
			end else if (gate_done) begin
				if (avg_cnt_q == `AVG_COUNT - 7'h01) begin
					avg_cnt_q <= 7'h00;
					avg_sum_q <= '0;
					avg_value <= DW'((avg_sum_q + (DW+7)'(meas_value)) / (DW+7)'(10));
					avg_valid <= 1'b1;
				end else begin
					avg_cnt_q <= avg_cnt_q + 7'h01;
					avg_sum_q <= avg_sum_q + (DW+7)'(meas_value);
				end
			end
		end
	end

	assign result = null_q ? meas_value - null_store : meas_value;

	// Display value and formatting
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			display_value <= '0;
			digits_shown  <= `RES_RESET;
			half_zero_pad <= 1'b0;
			exp_notation  <= 1'b0;
			overflow_led  <= 1'b0;
		end else begin
			if (gate_done && !avg_q)
				display_value <= result;
			else if (avg_valid)
				display_value <= avg_value;
			unique case (func_q)
				FN_RATIO: digits_shown <= (res_q > `RATIO_MAX_DIGITS) ? `RATIO_MAX_DIGITS : res_q;
				FN_PHASE: digits_shown <= phase_in_above_100khz ? `PHASE_HI_DIGITS
					: `PHASE_LO_DIGITS;
				default:  digits_shown <= avg_q ? res_q + 4'h1 : res_q;
			endcase
			half_zero_pad <= (func_q == FN_PHASE) && phase_in_above_100khz;
			// Exponent follows the last gated count, not the value between gates
			if (gate_done || (func_q != FN_GATED_TOTAL && func_q != FN_TOTAL_A))
				exp_notation <= ((func_q == FN_GATED_TOTAL) || (func_q == FN_TOTAL_A))
					&& (32'(meas_value) > `TOTAL_MAX);
			// Overrange past ten percent is flagged by the counter; eight digits, offset or averaging lights it
			overflow_led  <= meas_ovf && (res_q == `RES_MAX || null_q || avg_q);
		end
	end

	// Gate time from resolution, or from input frequency in phase
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			gate_ms  <= `GATE_MS_RES6;
			gate_avg <= 1'b0;
		end else begin
			gate_avg <= (res_q == `RES_MIN);
			if (func_q == FN_PHASE)
				gate_ms <= phase_in_above_200hz ? 14'(`PHASE_GATE_MS)
					: 14'(`PHASE_SLOW_GATE_MS);
			else
				unique case (res_q)
					4'h8:    gate_ms <= `GATE_MS_RES8;
					4'h7:    gate_ms <= `GATE_MS_RES7;
					4'h6:    gate_ms <= `GATE_MS_RES6;
					4'h5:    gate_ms <= `GATE_MS_RES5;
					default: gate_ms <= `GATE_MS_RES4;
				endcase
		end
	end

	// Error codes
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			err_code <= `ERR_NONE;
		end else if (func_chg) begin
			err_code <= `ERR_NONE;
		end else if (func_q == FN_CHECK && check_fail) begin
			err_code <= `ERR_CHECK;
		end else if (func_q == FN_PHASE && phase_in_above_5mhz) begin
			err_code <= `ERR_PHASE_HI;
		end else if (func_q == FN_PHASE && phase_freq_mismatch) begin
			err_code <= `ERR_PHASE_FREQ;
		end else if (cnt_ovf) begin
			err_code <= `ERR_CNT_OVF;
		end else if (meas_ovf && res_q == `RES_MAX) begin
			err_code <= `ERR_RANGE;
		end else if (prog_err) begin
			err_code <= `ERR_PROG;
		end else if (entry_err) begin
			err_code <= `ERR_ENTRY;
		end else if (gate_done && err_code != `ERR_ENTRY && err_code != `ERR_PROG
			&& err_code != `ERR_CHECK) begin
			err_code <= `ERR_NONE;
		end
	end

	// Indicators
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			resolution   <= `RES_RESET;
			res_ctrl_led <= 1'b0;
			null_led     <= 1'b0;
			delay_led    <= 1'b0;
			delay_en     <= 1'b0;
			chan_b_freq  <= 1'b0;
			avg_led      <= 1'b0;
			gate_led     <= 1'b0;
		end else begin
			resolution   <= res_q;
			res_ctrl_led <= res_ok | blink_on;
			null_led     <= null_q | blink_on;
			delay_led    <= dly_en_q | chb_q | blink_on;
			delay_en     <= dly_en_q;
			chan_b_freq  <= chb_q;
			avg_led      <= avg_q | blink_on;
			gate_led     <= gate_done;
		end
	end
endmodule // meas_ctl

//--- verification/meas_ctl_chk.sv
// Assertion checker for the measurement control block
`timescale 1ns/1ns
`include "meas_ctl_cfg.svh"
module meas_ctl_chk
	import meas_ctl_pkg::*;
#(
	parameter int DW       = 32,
	parameter int HOLD_MS  = 3000,
	parameter int BLINK_MS = 1500,
	parameter int TICK_CYC = 10000
) (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic [3:0]  func_sel,
	input wire logic        key_res_up,
	input wire logic        key_null,
	input wire logic        gate_done,
	input wire logic        check_fail,
	input wire logic [3:0]  resolution,
	input wire logic [3:0]  digits_shown,
	input wire logic [13:0] gate_ms,
	input wire logic        null_led,
	input wire logic [12:0] delay_val,
	input wire logic        delay_en,
	input wire logic        delay_led,
	input wire logic        gate_led,
	input wire logic        avg_valid,
	input wire logic        chan_b_freq,
	input wire logic        blink_on,
	input wire logic [5:0]  err_code
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	res_range_a: assert property (resolution >= `RES_MIN && resolution <= `RES_MAX)
		else $error("resolution out of range");
	res_reset_a: assert property ($rose(resetn) |-> resolution == `RES_RESET)
		else $error("resolution not six after reset");
	gate_map_a: assert property ((resolution == 4'h8 && func_sel == FN_FREQ_A) [*4]
		|-> gate_ms == 14'h2710) else $error("gate time wrong at eight digits");
	ratio_dig_a: assert property ((func_sel == FN_RATIO) [*3]
		|-> digits_shown <= `RATIO_MAX_DIGITS) else $error("too many ratio digits");
	null_block_a: assert property ((func_sel == FN_PHASE) [*4] |-> !null_led)
		else $error("offset mode on in phase");
	null_on_a: assert property (key_null && !null_led && func_sel == FN_FREQ_A
		|-> ##2 null_led) else $error("offset lamp late");
	res_lock_a: assert property (key_res_up && func_sel == FN_TOTAL_A
		|=> $stable(resolution) [*3]) else $error("resolution moved when locked");
	delay_rng_a: assert property (delay_val >= `DELAY_MIN && delay_val <= `DELAY_MAX)
		else $error("delay out of range");
	delay_lamp_a: assert property ($rose(delay_en) |-> ##[0:2] delay_led)
		else $error("delay lamp not lit");
	gate_pulse_a: assert property (gate_led |=> !gate_led)
		else $error("gate lamp pulse too long");
	err_check_a: assert property (check_fail && func_sel == FN_CHECK && gate_done
		|-> ##[1:2] err_code == `ERR_CHECK) else $error("check error code missing");
	avg_c: cover property (avg_valid);
	chanb_c: cover property ($rose(chan_b_freq));
	blink_c: cover property ($rose(blink_on));
endmodule // meas_ctl_chk

bind meas_ctl meas_ctl_chk #(.DW(DW), .HOLD_MS(HOLD_MS), .BLINK_MS(BLINK_MS),
	.TICK_CYC(TICK_CYC)) chk_i (.mclk(mclk), .resetn(resetn), .func_sel(func_sel),
	.key_res_up(key_res_up), .key_null(key_null), .gate_done(gate_done),
	.check_fail(check_fail), .resolution(resolution), .digits_shown(digits_shown),
	.gate_ms(gate_ms), .null_led(null_led), .delay_val(delay_val), .delay_en(delay_en),
	.delay_led(delay_led), .gate_led(gate_led), .avg_valid(avg_valid),
	.chan_b_freq(chan_b_freq), .blink_on(blink_on), .err_code(err_code));

//--- verification/meas_src_model.sv
// Conditioned input model that ends each gate with a measured value
`timescale 1ns/1ns
module meas_src_model (
	input  wire logic        mclk,
	input  wire logic        req,
	input  wire logic [1:0]  lag,
	input  wire logic [31:0] val,
	output logic             gate_done,
	output logic [31:0]      meas_value
);
	logic [1:0]  cnt_q = 2'h0;
	logic [31:0] hold_q = 32'h0;
	initial gate_done = 1'h0;
	initial meas_value = 32'h0;
	always @(posedge mclk) begin
		gate_done <= 1'h0;
		// Value is only valid with gate_done, so it churns otherwise
		meas_value <= ~meas_value;
		if (req) begin
			hold_q <= val;
			cnt_q <= lag;
		end else if (cnt_q != 2'h0) begin
			cnt_q <= cnt_q - 2'h1;
			if (cnt_q == 2'h1) begin
				gate_done <= 1'h1;
				meas_value <= hold_q;
			end
		end
	end
endmodule // meas_src_model

//--- verification/meas_ctl_tb_top.sv
// Self-checking testbench for the measurement control block
`timescale 1ns/1ns
module meas_ctl_tb_top;
	import meas_ctl_pkg::*;
	localparam int HOLD = 5;
	localparam int TICK = 4;
	logic        mclk, gd, gl, av, bl, nl, de, dl, cb, ga, hz, ex, ov, rl, al;
	logic        resetn = 1'h0;
	logic        kd = 1'h0;
	logic        req = 1'h0;
	logic [1:0]  lag = 2'h3;
	logic [7:0]  kv = 8'h00;
	// Bit 7 input above 100 kHz, bit 8 input above 200 Hz
	logic [8:0]  ev = 9'h100;
	logic [3:0]  fs = FN_FREQ_A;
	logic [3:0]  res, ds;
	logic [13:0] gms;
	logic [12:0] dv;
	logic [5:0]  ec;
	logic [31:0] rv = 32'h0;
	logic [31:0] mv, disp, ns, avv, av_q;
	logic [31:0] gexp [6] = '{32'h3E8, 32'h64, 32'hA, 32'h1, 32'h1, 32'h1};
	int          n_mismatch = 0, compares = 0, cyc = 0, n_gl = 0, n_av = 0, n_bl = 0;
	meas_ctl #(.HOLD_MS(HOLD), .BLINK_MS(3), .TICK_CYC(TICK)) dut (
		.mclk(mclk), .resetn(resetn), .func_sel(fs), .key_res_up(kv[0]), .key_res_down(kv[1]),
		.key_null(kv[2]), .key_delay_raw(kd), .key_up(kv[3]), .key_down(kv[4]),
		.key_reset(kv[5]), .key_recall(kv[6]), .key_hundred_reading_average(kv[7]),
		.gate_done(gd), .meas_value(mv), .meas_ovf(ev[6]), .cnt_ovf(ev[1]),
		.phase_freq_mismatch(ev[0]), .phase_in_above_5mhz(ev[2]), .phase_in_above_100khz(ev[7]),
		.phase_in_above_200hz(ev[8]), .entry_err(ev[3]), .prog_err(ev[4]), .check_fail(ev[5]),
		.resolution(res), .digits_shown(ds), .half_zero_pad(hz), .exp_notation(ex),
		.overflow_led(ov), .gate_ms(gms), .gate_avg(ga), .res_ctrl_led(rl), .null_led(nl),
		.display_value(disp), .null_store(ns), .delay_led(dl), .delay_en(de), .delay_val(dv),
		.chan_b_freq(cb), .avg_led(al), .gate_led(gl), .avg_value(avv), .avg_valid(av),
		.blink_on(bl), .err_code(ec));
	meas_src_model src (.mclk(mclk), .req(req), .lag(lag), .val(rv), .gate_done(gd),
		.meas_value(mv));
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		n_gl <= n_gl + int'(gl);
		n_av <= n_av + int'(av);
		n_bl <= n_bl + int'(bl);
		if (av) av_q <= avv;
		if (cyc == 10000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic key(input int k);
		kv[k] = 1'h1;
		wt(1);
		kv[k] = 1'h0;
		wt(3);
	endtask
	task automatic dkey(input int n);
		kd = 1'h1;
		wt(n);
		kd = 1'h0;
		wt(5);
	endtask
	task automatic gate(input logic [31:0] v);
		rv = v;
		req = 1'h1;
		wt(1);
		req = 1'h0;
		for (int i = 0; i < 10 && gd !== 1'h1; i++) @(negedge mclk);
		wt(3);
	endtask
	task automatic errc(input int b, input logic [3:0] f, input logic [5:0] c, input bit fc);
		fs = f;
		wt(2);
		ev[b] = 1'h1;
		gate(32'h10);
		chk(ec, c);
		ev[b] = 1'h0;
		if (fc) fs = FN_TIME;
		gate(32'h10);
		chk(ec, 32'h0);
	endtask
	initial begin
		wt(12);
		resetn = 1'h1;
		wt(2);
		chk(res, 32'h6);
		chk(dv, 32'h32);
		chk(gms, 32'h64);
		chk(rl, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 3; i++) key(0);
		chk(res, 32'h8);
		chk(gms, 32'h2710);
		ev[6] = 1'h1;
		gate(32'h10);
		chk(ov, 32'h1);
		chk(ec, 32'h2);
		ev[6] = 1'h0;
		gate(32'h10);
		chk(ov, 32'h0);
		chk(ec, 32'h0);
		for (int i = 0; i < 6; i++) begin
			key(1);
			chk(res, 32'(i < 5 ? 7 - i : 3));
			chk(gms, gexp[i]);
		end
		chk(ga, 32'h1);
		for (int i = 0; i < 3; i++) key(0);
		fs = FN_TOTAL_A;
		wt(2);
		key(0);
		chk(res, 32'h6);
		chk(rl, 32'h0);
		gate(32'h05F5E100);
		chk(ex, 32'h1);
		gate(32'h05F5E0FF);
		chk(ex, 32'h0);
		fs = FN_RATIO;
		wt(4);
		chk(ds, 32'h6);
		$display("test resolution done");
		fs = FN_FREQ_A;
		gate(32'h3E8);
		key(2);
		chk(nl, 32'h1);
		chk(ns, 32'h3E8);
		gate(32'h5DC);
		chk(disp, 32'h1F4);
		ev[6] = 1'h1;
		wt(3);
		chk(ov, 32'h1);
		ev[6] = 1'h0;
		key(2);
		gate(32'h5DC);
		chk(nl, 32'h0);
		chk(disp, 32'h5DC);
		chk(ns, 32'h3E8);
		key(2);
		chk(nl, 32'h1);
		fs = FN_PHASE;
		wt(2);
		key(2);
		chk(nl, 32'h0);
		chk(ds, 32'h4);
		chk(gms, 32'h32);
		ev[7] = 1'h1;
		wt(3);
		chk(ds, 32'h3);
		chk(hz, 32'h1);
		ev[7] = 1'h0;
		ev[8] = 1'h0;
		wt(3);
		chk(gms, 32'h1F4);
		ev[8] = 1'h1;
		$display("test offset done");
		fs = FN_TI;
		wt(2);
		dkey(2);
		chk(de, 32'h1);
		chk(dl, 32'h1);
		dkey(2);
		chk(de, 32'h0);
		chk(dl, 32'h0);
		for (int i = 0; i < 60; i++) key(4);
		key(5);
		chk(dv, 32'h1);
		key(3);
		dkey(2);
		chk(de, 32'h1);
		chk(dv, 32'h2);
		fs = FN_PERIOD;
		wt(4);
		chk(de, 32'h0);
		dkey(2);
		chk(de, 32'h0);
		$display("test delay done");
		fs = FN_FREQ_A;
		wt(2);
		dkey((HOLD + 2) * TICK + 4);
		chk(cb, 32'h1);
		chk(dl, 32'h1);
		key(5);
		chk(cb, 32'h0);
		dkey((HOLD + 2) * TICK + 4);
		chk(cb, 32'h1);
		dkey(2);
		chk(cb, 32'h0);
		chk(dl, 32'h0);
		$display("test channel b done");
		key(7);
		chk(al, 32'h1);
		chk(ds, 32'h7);
		for (int i = 0; i < 50; i++) gate(32'h9);
		key(5);
		n_gl = 0;
		n_av = 0;
		for (int i = 0; i < 100; i++) begin
			lag = 2'(1 + i % 3);
			gate(32'h7);
			if (i == 98) chk(n_av, 32'h0);
		end
		wt(10);
		chk(n_av, 32'h1);
		chk(av_q, 32'h46);
		chk(n_gl, 32'h64);
		key(7);
		chk(al, 32'h0);
		lag = 2'h3;
		$display("test average done");
		errc(0, FN_PHASE, 6'h01, 0);
		errc(1, FN_FREQ_A, 6'h03, 0);
		errc(2, FN_PHASE, 6'h06, 0);
		errc(3, FN_FREQ_A, 6'h04, 1);
		errc(4, FN_PERIOD, 6'h05, 1);
		errc(5, FN_CHECK, 6'h32, 1);
		$display("test errors done");
		fs = FN_CHECK;
		wt(2);
		key(6);
		n_bl = 0;
		wt(30);
		chk(n_bl > 0 && n_bl < 30, 32'h1);
		key(5);
		chk(bl, 32'h0);
		$display("test blink done");
		complete_run();
	end
endmodule // meas_ctl_tb_top
